// ==== hw/block_tx_pkg.sv ====
// Package for the automatic block send sequencer.
// Holds the register map, field positions, reset values and state codes.
package block_tx_pkg;

  // ==========================================================================
  // Sizes
  // ==========================================================================
  localparam int NUM_BUF = 16;
  localparam int NUM_BLOCK = 8;
  localparam int ID_W = 11;
  localparam logic [2:0] LAST_BLOCK = 3'h7;

  // ==========================================================================
  // Register byte addresses
  // ==========================================================================
  localparam logic [7:0] ADDR_MODULE_CTRL = 8'h00;
  localparam logic [7:0] ADDR_BLOCK_CTRL = 8'h04;
  localparam logic [7:0] ADDR_GAP_DELAY = 8'h08;
  localparam logic [7:0] ADDR_BUF_READY = 8'h0C;
  localparam logic [7:0] ADDR_SEND_REQ = 8'h10;
  localparam logic [7:0] ADDR_HISTORY = 8'h14;

  // ==========================================================================
  // Fields, codes and reset values
  // ==========================================================================
  localparam logic [2:0] MODE_INIT = 3'h0;
  localparam logic [2:0] MODE_BLOCK_SEND = 3'h2;
  localparam int BIT_TX_ACTIVE = 8;
  localparam int BIT_TRIGGER = 0;
  localparam int BIT_POS_RESET = 1;
  localparam int POS_LSB = 4;
  localparam int HIST_VALID_BIT = 8;
  localparam logic [7:0] GAP_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Sequencer states, Gray coded along idle, gap, pending.
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_GAP = 2'b01,
    SEQ_PEND = 2'b11
  } seq_state_t;

endpackage

// ==== hw/block_tx_sequencer.sv ====
// Automatic block send sequencer with transmit arbitration and abort handling.
// Assumes an AXI4-Lite master, a bit timing block giving one bit_tick per
// bus data bit, and a protocol engine that sends the buffer named on tx_start.
// Notes on behaviour
// - Block sending uses buffers zero through seven only.
// - Mode code 010B enables block send operation.
// - Trigger requests the buffer at the current position, completion requests next.
// - Wait programmed gap, in bit times, between frames.
// - Block buffers go strictly in ascending order.
// - After buffer seven, trigger clears and sequence ends.
// - Unready buffer stops sequence, clears trigger, keeps position.
// - Position reset while stopped restarts at buffer zero.
// - Position reset bit clears itself when done.
// - Pending block buffer arbitrates with ordinary buffers.
// - Block frames are never logged in history.
// - Zero gap may let ordinary frames pass.
// - Received foreign frame may delay next block frame.
// - Clearing a request aborts it unless on bus.
// - Trigger stays one until active block frame ends.
module block_tx_sequencer
  import block_tx_pkg::*;
#(
  parameter int GAP_W = 8
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic [NUM_BUF*ID_W-1:0] buffer_id,
  input wire logic bit_tick,
  output logic tx_start,
  output logic [3:0] tx_buffer,
  output logic transmit_active_flag,
  input wire logic tx_done,
  input wire logic tx_ok
);

  // ==========================================================================
  // State
  // ==========================================================================
  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [7:0] wa_reg, wa_next;
  logic [31:0] wd_reg, wd_next;
  logic [3:0] ws_reg, ws_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [2:0] operating_mode_field_reg, operating_mode_field_next;
  logic block_send_trigger_reg, block_send_trigger_next;
  logic sequencer_position_reset_reg, sequencer_position_reset_next;
  logic abort_reg, abort_next;
  logic [2:0] pos_reg, pos_next;
  logic [GAP_W-1:0] block_gap_delay_reg, block_gap_delay_next;
  logic [GAP_W-1:0] gap_cnt_reg, gap_cnt_next;
  seq_state_t state_reg, state_next;
  logic [NUM_BUF-1:0] ready_reg, ready_next, req_reg, req_next;
  logic busy_reg, busy_next, start_reg, start_next;
  logic [3:0] txbuf_reg, txbuf_next, hist_reg, hist_next;
  logic hist_v_reg, hist_v_next;
  logic wr_go, rd_go, block_mode, block_done, any_cand;
  logic [3:0] win;
  logic [ID_W-1:0] win_id;
  logic [NUM_BUF-1:0] cand;
  logic [31:0] wmask;

  assign awready = !aw_have_reg;
  assign wready = !w_have_reg;
  assign arready = !rvalid_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rresp = rresp_reg;
  assign rdata = rdata_reg;
  assign tx_start = start_reg;
  assign tx_buffer = txbuf_reg;
  assign transmit_active_flag = busy_reg;
  assign wr_go = aw_have_reg && w_have_reg && !bvalid_reg;
  assign rd_go = arvalid && !rvalid_reg;
  assign block_mode = (operating_mode_field_reg == MODE_BLOCK_SEND);
  assign wmask = {{8{ws_reg[3]}}, {8{ws_reg[2]}}, {8{ws_reg[1]}}, {8{ws_reg[0]}}};
  // A block frame ended on the bus; only buffers 0 to 7 take part.
  assign block_done = busy_reg && tx_done && block_mode && !txbuf_reg[3];

  // Merges the written bytes into an old register value.
  function automatic logic [31:0] merge(input logic [31:0] old);
    merge = (old & ~wmask) | (wd_reg & wmask);
  endfunction

  // ==========================================================================
  // Arbitration
  // ==========================================================================
  // Each requesting buffer is a candidate; in block mode at most one block
  // buffer holds a request, so block order is never decided by identifier.
  generate
    for (genvar i = 0; i < NUM_BUF; i++)
    begin : g_cand
      assign cand[i] = req_reg[i];
    end
  endgenerate

  // Lowest identifier wins, ties go to the lowest buffer number.
  always_comb
  begin
    win = 4'h0;
    win_id = '1;
    any_cand = 1'b0;
    for (int i = 0; i < NUM_BUF; i++)
    begin
      if (cand[i] && (!any_cand || buffer_id[i*ID_W +: ID_W] < win_id))
      begin
        win = 4'(i);
        win_id = buffer_id[i*ID_W +: ID_W];
        any_cand = 1'b1;
      end
    end
  end

  // ==========================================================================
  // Bus slave next state
  // ==========================================================================
  always_comb
  begin
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    wa_next = wa_reg;
    wd_next = wd_reg;
    ws_next = ws_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (awvalid && !aw_have_reg)
    begin
      aw_have_next = 1'b1;
      wa_next = awaddr;
    end
    if (wvalid && !w_have_reg)
    begin
      w_have_next = 1'b1;
      wd_next = wdata;
      ws_next = wstrb;
    end
    if (wr_go)
    begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = (wa_reg > ADDR_HISTORY || wa_reg[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
    end
    if (bvalid_reg && bready)
    begin
      bvalid_next = 1'b0;
    end
    if (rvalid_reg && rready)
    begin
      rvalid_next = 1'b0;
    end
    if (rd_go)
    begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      rdata_next = 32'h0;
      case (araddr)
        ADDR_MODULE_CTRL:
        begin
          rdata_next[2:0] = operating_mode_field_reg;
          rdata_next[BIT_TX_ACTIVE] = busy_reg;
        end
        ADDR_BLOCK_CTRL:
        begin
          rdata_next[BIT_TRIGGER] = block_send_trigger_reg;
          rdata_next[BIT_POS_RESET] = sequencer_position_reset_reg;
          rdata_next[POS_LSB +: 3] = pos_reg;
        end
        ADDR_GAP_DELAY: rdata_next[GAP_W-1:0] = block_gap_delay_reg;
        ADDR_BUF_READY: rdata_next[NUM_BUF-1:0] = ready_reg;
        ADDR_SEND_REQ: rdata_next[NUM_BUF-1:0] = req_reg;
        ADDR_HISTORY:
        begin
          rdata_next[3:0] = hist_reg;
          rdata_next[HIST_VALID_BIT] = hist_v_reg;
        end
        default: rresp_next = RESP_SLVERR;
      endcase
    end
  end

  // ==========================================================================
  // Sequencer and transmit next state
  // ==========================================================================
  always_comb
  begin
    logic [31:0] m;
    m = 32'h0;
    operating_mode_field_next = operating_mode_field_reg;
    block_send_trigger_next = block_send_trigger_reg;
    sequencer_position_reset_next = 1'b0;
    abort_next = abort_reg;
    pos_next = pos_reg;
    block_gap_delay_next = block_gap_delay_reg;
    gap_cnt_next = gap_cnt_reg;
    state_next = state_reg;
    ready_next = ready_reg;
    req_next = req_reg;
    busy_next = busy_reg;
    start_next = 1'b0;
    txbuf_next = txbuf_reg;
    hist_next = hist_reg;
    hist_v_next = hist_v_reg;
    // History pop on read; a new entry in the same cycle wins below.
    if (rd_go && araddr == ADDR_HISTORY)
    begin
      hist_v_next = 1'b0;
    end
    // Frame completion: requests clear only after a good frame.
    if (busy_reg && tx_done)
    begin
      busy_next = 1'b0;
      if (tx_ok)
      begin
        req_next[txbuf_reg] = 1'b0;
        if (!block_done)
        begin
          hist_next = txbuf_reg;
          hist_v_next = 1'b1;
        end
      end
    end
    // A pending position reset is carried out and the bit drops.
    if (sequencer_position_reset_reg)
    begin
      pos_next = 3'h0;
    end
    case (state_reg)
      SEQ_IDLE:
      begin
        if (block_send_trigger_reg && block_mode)
        begin
          if (ready_reg[pos_reg])
          begin
            req_next[pos_reg] = 1'b1;
            state_next = SEQ_PEND;
          end
          else
          begin
            block_send_trigger_next = 1'b0;
          end
        end
      end
      SEQ_PEND:
      begin
        if (block_done && tx_ok)
        begin
          abort_next = 1'b0;
          gap_cnt_next = '0;
          if (pos_reg == LAST_BLOCK)
          begin
            pos_next = 3'h0;
            block_send_trigger_next = 1'b0;
            state_next = SEQ_IDLE;
          end
          else
          begin
            pos_next = pos_reg + 3'h1;
            state_next = abort_reg ? SEQ_IDLE : SEQ_GAP;
            block_send_trigger_next = !abort_reg;
          end
        end
        else if (block_done && abort_reg)
        begin
          // Failed frame under abort: stay on the same buffer.
          abort_next = 1'b0;
          req_next[pos_reg] = 1'b0;
          block_send_trigger_next = 1'b0;
          state_next = SEQ_IDLE;
        end
      end
      SEQ_GAP:
      begin
        if (gap_cnt_reg >= block_gap_delay_reg)
        begin
          if (ready_reg[pos_reg])
          begin
            req_next[pos_reg] = 1'b1;
            state_next = SEQ_PEND;
          end
          else
          begin
            block_send_trigger_next = 1'b0;
            state_next = SEQ_IDLE;
          end
        end
        else if (bit_tick)
        begin
          gap_cnt_next = gap_cnt_reg + 1'b1;
        end
      end
      default: state_next = SEQ_IDLE;
    endcase
    // Launch the arbitration winner when the engine is free.
    if (!busy_reg && any_cand)
    begin
      busy_next = 1'b1;
      start_next = 1'b1;
      txbuf_next = win;
    end
    // Software writes.
    if (wr_go)
    begin
      case (wa_reg)
        ADDR_MODULE_CTRL:
        begin
          m = merge({29'h0, operating_mode_field_reg});
          operating_mode_field_next = m[2:0];
        end
        ADDR_BLOCK_CTRL:
        begin
          m = merge({30'h0, sequencer_position_reset_reg, block_send_trigger_reg});
          if (m[BIT_TRIGGER] && block_mode)
          begin
            block_send_trigger_next = 1'b1;
          end
          else if (!m[BIT_TRIGGER] && block_send_trigger_reg)
          begin
            if (busy_reg && !txbuf_reg[3] && state_reg == SEQ_PEND)
            begin
              abort_next = 1'b1;
            end
            else
            begin
              block_send_trigger_next = 1'b0;
              req_next[pos_reg] = 1'b0;
              state_next = SEQ_IDLE;
            end
          end
          if (m[BIT_POS_RESET] && !block_send_trigger_reg)
          begin
            sequencer_position_reset_next = 1'b1;
          end
        end
        ADDR_GAP_DELAY:
        begin
          m = merge({{(32-GAP_W){1'b0}}, block_gap_delay_reg});
          block_gap_delay_next = m[GAP_W-1:0];
        end
        ADDR_BUF_READY:
        begin
          m = merge({16'h0, ready_reg});
          ready_next = m[NUM_BUF-1:0];
        end
        ADDR_SEND_REQ:
        begin
          m = merge({16'h0, req_reg});
          for (int i = 0; i < NUM_BUF; i++)
          begin
            // Block buffers belong to hardware while in block mode.
            if (!block_mode || i >= NUM_BLOCK)
            begin
              if (m[i])
              begin
                req_next[i] = 1'b1;
              end
              else if (!(busy_reg && txbuf_reg == 4'(i)))
              begin
                req_next[i] = 1'b0;
              end
            end
          end
        end
        default: m = 32'h0;
      endcase
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      wa_reg <= 8'h00;
      wd_reg <= 32'h0;
      ws_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h0;
      operating_mode_field_reg <= MODE_INIT;
      block_send_trigger_reg <= 1'b0;
      sequencer_position_reset_reg <= 1'b0;
      abort_reg <= 1'b0;
      pos_reg <= 3'h0;
      block_gap_delay_reg <= GAP_RESET;
      gap_cnt_reg <= '0;
      state_reg <= SEQ_IDLE;
      ready_reg <= 16'h0;
      req_reg <= 16'h0;
      busy_reg <= 1'b0;
      start_reg <= 1'b0;
      txbuf_reg <= 4'h0;
      hist_reg <= 4'h0;
      hist_v_reg <= 1'b0;
    end
    else
    begin
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      wa_reg <= wa_next;
      wd_reg <= wd_next;
      ws_reg <= ws_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      operating_mode_field_reg <= operating_mode_field_next;
      block_send_trigger_reg <= block_send_trigger_next;
      sequencer_position_reset_reg <= sequencer_position_reset_next;
      abort_reg <= abort_next;
      pos_reg <= pos_next;
      block_gap_delay_reg <= block_gap_delay_next;
      gap_cnt_reg <= gap_cnt_next;
      state_reg <= state_next;
      ready_reg <= ready_next;
      req_reg <= req_next;
      busy_reg <= busy_next;
      start_reg <= start_next;
      txbuf_reg <= txbuf_next;
      hist_reg <= hist_next;
      hist_v_reg <= hist_v_next;
    end
  end

endmodule

// ==== verification/block_tx_sequencer_assertions.sv ====
// Concurrent checks on the ports of the block send sequencer.
// Assumes it is bound into block_tx_sequencer, one clock aclk, reset aresetn.
module block_tx_checker
  import block_tx_pkg::*;
#(
  parameter int GAP_W = 8
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [7:0] araddr,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic [NUM_BUF*ID_W-1:0] buffer_id,
  input wire logic bit_tick,
  input wire logic tx_start,
  input wire logic [3:0] tx_buffer,
  input wire logic transmit_active_flag,
  input wire logic tx_done,
  input wire logic tx_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Assertions
  // ==========================================================================
  // All checks share the one clock and are quiet during reset.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_start_pulse:
    assert property (tx_start |=> !tx_start) else $error("start pulse too long");
  chk_active_on:
    assert property (tx_start |-> ##[0:1] transmit_active_flag) else $error("not active");
  chk_one_frame:
    assert property (transmit_active_flag && !tx_done |=> !tx_start)
    else $error("second frame started while busy");
  chk_active_hold:
    assert property (transmit_active_flag && !tx_done |=> transmit_active_flag)
    else $error("active dropped before frame end");
  chk_active_ends:
    assert property (transmit_active_flag && tx_done |-> ##[1:2] !transmit_active_flag)
    else $error("active stuck after frame end");
  chk_buffer_held:
    assert property (!tx_start |-> $stable(tx_buffer)) else $error("buffer moved without start");
  chk_write_answer:
    assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("no write response");
  chk_bresp_hold:
    assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  chk_read_answer:
    assert property (arvalid && arready |=> rvalid) else $error("no read data");
  chk_rdata_hold:
    assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  chk_read_block:
    assert property (rvalid |-> !arready) else $error("read taken while answer pending");

  cover property (tx_start && tx_buffer == 4'h7);
  cover property (tx_done && !tx_ok);
  cover property (bvalid && bresp == RESP_SLVERR);
endmodule

bind block_tx_sequencer block_tx_checker #(.GAP_W(GAP_W)) chk_u (.*);

// ==== verification/can_node_model.sv ====
// Behavioural model of the protocol engine and the other nodes on the bus.
// Assumes one clock; the bench sets the frame length and whether frames fail.
module can_node_model
#(
  parameter int TICK = 4
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tx_start,
  input wire logic [7:0] frame_len,
  input wire logic fail_next,
  output logic tx_done,
  output logic tx_ok,
  output logic bit_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  int tcnt;
  logic busy;
  // ==========================================================================
  // Frame timing
  // ==========================================================================
  // A frame lasts frame_len cycles; a long one stands for a foreign frame too.
  always @(posedge aclk)
  begin
    tx_done <= 1'b0;
    if (!aresetn)
      busy <= 1'b0;
    else if (tx_start)
    begin
      busy <= 1'b1;
      cnt <= frame_len;
    end
    else if (busy && cnt <= 1)
    begin
      busy <= 1'b0;
      tx_done <= 1'b1;
    end
    else if (busy)
      cnt <= cnt - 1;
  end
  // One tick per bus data bit time, running from the module clock.
  always @(posedge aclk)
  begin
    tcnt <= (!aresetn || tcnt == TICK - 1) ? 0 : tcnt + 1;
    bit_tick <= aresetn && tcnt == TICK - 1;
  end
  // Outcome is only meaningful with done; otherwise it toggles.
  assign tx_ok = tx_done ? !fail_next : tcnt[0];
endmodule

// ==== verification/test_block_tx_sequencer.sv ====
// Self-checking bench for the block send sequencer.
// Assumes the package block_tx_pkg and the node model can_node_model.
module test_block_tx_sequencer
  import block_tx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, fail_next;
  logic awready, wready, bvalid, arready, rvalid, tx_start, active, tx_done, tx_ok, bit_tick;
  logic [7:0] awaddr, araddr, frame_len;
  logic [31:0] wdata, rdata, rd_val;
  logic [3:0] tx_buffer;
  logic [1:0] bresp, rresp;
  logic [NUM_BUF*ID_W-1:0] buffer_id;
  logic [3:0] sent[$];
  int miscompares, cmp_count, cycles, ticks, gap_set, gap_bad;

  block_tx_sequencer dut_u (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .buffer_id(buffer_id), .bit_tick(bit_tick), .tx_start(tx_start),
    .tx_buffer(tx_buffer), .transmit_active_flag(active), .tx_done(tx_done), .tx_ok(tx_ok));
  can_node_model node_u (.aclk(aclk), .aresetn(aresetn), .tx_start(tx_start),
    .frame_len(frame_len), .fail_next(fail_next), .tx_done(tx_done), .tx_ok(tx_ok),
    .bit_tick(bit_tick));

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ap;
    bit wp;
    ap = 1;
    wp = 1;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    while (ap || wp)
    begin
      @(posedge aclk);
      if (ap && awready === 1'b1)
      begin
        ap = 0;
        awvalid <= 1'b0;
      end
      if (wp && wready === 1'b1)
      begin
        wp = 0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    chk_val(bresp, er);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    chk_val(rresp, RESP_OKAY);
    rready <= 1'b0;
  endtask

  // Triggers a block run and waits until the trigger reads zero again.
  task automatic run_block(input logic [15:0] rdy, input logic [3:0] first,
    input logic [3:0] last, input logic [2:0] pos);
    wr(ADDR_BUF_READY, {16'h0, rdy}, RESP_OKAY);
    sent.delete();
    wr(ADDR_BLOCK_CTRL, 32'h1, RESP_OKAY);
    do rd(ADDR_BLOCK_CTRL, rd_val); while (rd_val[BIT_TRIGGER] !== 1'b0);
    chk_val(sent.size(), last - first + 1);
    for (int i = 0; i < sent.size(); i++)
      chk_val(sent[i], first + i);
    chk_val(rd_val[POS_LSB +: 3], pos);
  endtask

  // ==========================================================================
  // Clock, monitor and timeout
  // ==========================================================================
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Records started frames and bit ticks since the last frame end.
  always @(posedge aclk)
  begin
    cycles++;
    if (tx_start === 1'b1)
      sent.push_back(tx_buffer);
    if (tx_start === 1'b1 && tx_buffer < 8 && tx_buffer != 0 && ticks + 1 < gap_set)
      gap_bad++;
    ticks = (tx_done === 1'b1) ? 0 : ticks + int'(bit_tick === 1'b1);
    if (cycles == 30000)
    begin
      miscompares++;
      give_verdict;
    end
  end

  // ==========================================================================
  // Test sequence
  // ==========================================================================
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, fail_next} = 7'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    frame_len = 8'd20;
    buffer_id = {NUM_BUF{11'h400}};
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_MODULE_CTRL, rd_val);
    chk_val(rd_val, 32'h0);
    rd(ADDR_GAP_DELAY, rd_val);
    chk_val(rd_val, {24'h0, GAP_RESET});
    wr(8'h18, 32'h1, RESP_SLVERR);
    wr(ADDR_BLOCK_CTRL, 32'h1, RESP_OKAY);
    rd(ADDR_BLOCK_CTRL, rd_val);
    chk_val(rd_val[BIT_TRIGGER], 1'b0);
    $display("Test reset done");
    wr(ADDR_GAP_DELAY, 32'h3, RESP_OKAY);
    gap_set = 3;
    wr(ADDR_MODULE_CTRL, {29'h0, MODE_BLOCK_SEND}, RESP_OKAY);
    wr(ADDR_SEND_REQ, 32'h1, RESP_OKAY);
    rd(ADDR_SEND_REQ, rd_val);
    chk_val(rd_val[7:0], 8'h00);
    run_block(16'h00FF, 4'h0, 4'h7, 3'h0);
    chk_val(gap_bad, 0);
    rd(ADDR_HISTORY, rd_val);
    chk_val(rd_val[HIST_VALID_BIT], 1'b0);
    run_block(16'h00F7, 4'h0, 4'h2, 3'h3);
    run_block(16'h00FF, 4'h3, 4'h7, 3'h0);
    run_block(16'h0003, 4'h0, 4'h1, 3'h2);
    wr(ADDR_BLOCK_CTRL, 32'h2, RESP_OKAY);
    rd(ADDR_BLOCK_CTRL, rd_val);
    chk_val(rd_val[BIT_POS_RESET], 1'b0);
    run_block(16'h00FF, 4'h0, 4'h7, 3'h0);
    $display("Test block runs done");
    // Trigger cleared mid-frame: failed frame keeps place, good one moves on.
    frame_len <= 8'd60;
    for (int f = 0; f < 2; f++)
    begin
      fail_next <= (f == 0);
      wr(ADDR_BLOCK_CTRL, 32'h1, RESP_OKAY);
      do @(posedge aclk); while (active !== 1'b1);
      wr(ADDR_BLOCK_CTRL, 32'h0, RESP_OKAY);
      rd(ADDR_BLOCK_CTRL, rd_val);
      chk_val(rd_val[BIT_TRIGGER], 1'b1);
      do rd(ADDR_BLOCK_CTRL, rd_val); while (rd_val[BIT_TRIGGER] !== 1'b0);
      chk_val(rd_val[POS_LSB +: 3], f);
    end
    $display("Test abort done");
    // An ordinary request made during a block frame goes in the zero gap, before the next block one.
    wr(ADDR_BLOCK_CTRL, 32'h2, RESP_OKAY);
    wr(ADDR_GAP_DELAY, 32'h0, RESP_OKAY);
    gap_set = 0;
    buffer_id[9*ID_W +: ID_W] <= 11'h100;
    wr(ADDR_BUF_READY, 32'h02FF, RESP_OKAY);
    sent.delete();
    wr(ADDR_BLOCK_CTRL, 32'h1, RESP_OKAY);
    do @(posedge aclk); while (active !== 1'b1);
    wr(ADDR_SEND_REQ, 32'h0200, RESP_OKAY);
    do rd(ADDR_BLOCK_CTRL, rd_val); while (rd_val[BIT_TRIGGER] !== 1'b0);
    chk_val(sent.size(), 9);
    chk_val(sent[1], 4'h9);
    chk_val(sent[8], 4'h7);
    rd(ADDR_HISTORY, rd_val);
    chk_val(rd_val, 32'h109);
    $display("Test arbitration done");
    // Ordinary abort in block mode with the trigger at zero, then outside it.
    for (int md = 2; md >= 0; md -= 2)
    begin
      wr(ADDR_MODULE_CTRL, md, RESP_OKAY);
      wr(ADDR_SEND_REQ, 32'h0C00, RESP_OKAY);
      wr(ADDR_SEND_REQ, 32'h0, RESP_OKAY);
      chk_val(active, 1'b1);
      rd(ADDR_SEND_REQ, rd_val);
      chk_val(rd_val, 32'h0400);
      rd(ADDR_MODULE_CTRL, rd_val);
      chk_val(rd_val, 32'h100 | md);
      do @(posedge aclk); while (active !== 1'b0);
    end
    $display("Test ordinary abort done");
    give_verdict;
  end
endmodule
